// [hw/ptpcc_dev.sv]
`timescale 1ns/1ps
// Behaviour
// - target mask bits gate pending flags to interrupt
// - external event flags never interrupt
// - enabled target match sets pending, clears enable
// - pending with mask set requests interrupt
// - host writes target only while disabled
// - pps pin mirrors second pending when enabled
// - master select picks master or slave role
// - transmit mask gates transmit flag interrupt
// - receive mask gates receive flag interrupt
// - all enabled requests share one line
// - write one clears target pending flag
// - event edge captures time, holds while set
// - host polls flag before reading snapshot
// - transmitted sync/delay request captures time once
// - transmit flag with mask interrupts; w1c
// - received frame stores time and ids
// - sixteen-entry receive queue drops when full
// - receive flag clears only when queue empty
// - host drains queue until flag reads zero
// - addend accumulates; carry increments system time
// - addend resets to zero; host starts it
// - addend loads when high half written
// - accumulate once every clock cycle with ce_in high
module ptpcc_dev
  import ptpcc_pkg::*;
#(
  parameter int DEPTH = RXQ_DEPTH
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  ce_in,
  // host bus
  ptpcc_if.dev                       bus,
  // external event pins
  input  wire logic                  ext_input_a_in,
  input  wire logic                  ext_input_b_in,
  // frame detector pulses
  input  wire logic                  tx_sync_in,
  input  wire logic                  tx_delay_req_in,
  input  wire logic                  rx_sync_in,
  input  wire logic                  rx_delay_req_in,
  input  wire logic [ptpcc_pkg::IDW-1:0] rx_source_id_in,
  input  wire logic [ptpcc_pkg::IDW-1:0] rx_sequence_id_in,
  // outputs
  output logic                       pps_out,
  output logic                       rx_queue_full_out
);
  import ptpcc_pkg::*;

  localparam int QAW = $clog2(DEPTH);
  localparam int QEW = TW + 2 * IDW;

  //////////////////////////////////////////////////////////////////////////
  // register access decode

  logic [DW-1:0] ctrl_q;
  logic [1:0]    ttp_q;
  logic [DW-1:0] add_lo_q;
  logic [DW-1:0] add_hi_q;
  logic [TW-1:0] addend_q;
  logic [TW-1:0] accum_q;
  logic [TW-1:0] systime_q;
  logic [TW-1:0] tgt1_q;
  logic [TW-1:0] tgt2_q;
  logic [DW-1:0] rdata_q;
  logic          irq_n_q;
  logic          pps_q;
  logic          ext_a_q;
  logic          ext_b_q;

  wire wr_ctrl   = bus.wr && (bus.addr == OFS_CTRL);
  wire wr_event  = bus.wr && (bus.addr == OFS_EVENT);
  wire wr_add_lo = bus.wr && (bus.addr == OFS_ADD_LO);
  wire wr_add_hi = bus.wr && (bus.addr == OFS_ADD_HI);
  wire wr_t1_lo  = bus.wr && (bus.addr == OFS_TGT1_LO);
  wire wr_t1_hi  = bus.wr && (bus.addr == OFS_TGT1_HI);
  wire wr_t2_lo  = bus.wr && (bus.addr == OFS_TGT2_LO);
  wire wr_t2_hi  = bus.wr && (bus.addr == OFS_TGT2_HI);
  wire [DW-1:0] w1c = wr_event ? bus.wdata : '0;

  //////////////////////////////////////////////////////////////////////////
  // time base

  wire [TW:0] acc_sum = {1'b0, accum_q} + {1'b0, addend_q};
  wire        acc_carry = acc_sum[TW];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      accum_q   <= '0;
      systime_q <= '0;
      addend_q  <= '0;
      add_lo_q  <= REG_RST;
      add_hi_q  <= REG_RST;
    end else if (ce_in) begin
      accum_q <= acc_sum[TW-1:0];
      if (acc_carry) begin
        systime_q <= systime_q + 32'h0000_0001;
      end
      if (wr_add_lo) begin
        add_lo_q <= bus.wdata;
      end
      if (wr_add_hi) begin
        add_hi_q <= bus.wdata;
        addend_q <= {bus.wdata, add_lo_q};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // target compare

  wire match1 = ctrl_q[CTL_TTE1] && (systime_q == tgt1_q);
  wire match2 = ctrl_q[CTL_TTE2] && (systime_q == tgt2_q);

  logic [DW-1:0] ctrl_d;
  always_comb begin
    ctrl_d = wr_ctrl ? (bus.wdata & CTL_MASK) : ctrl_q;
    if (match1) begin
      ctrl_d[CTL_TTE1] = 1'b0;
    end
    if (match2) begin
      ctrl_d[CTL_TTE2] = 1'b0;
    end
  end

  // the pending flag set wins over a same-cycle write-one-to-clear
  wire [1:0] ttp_d = (ttp_q & ~w1c[EV_SECOND_TARGET_PENDING:EV_TTP1])
                   | {match2, match1};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= REG_RST;
      ttp_q  <= 2'b00;
      tgt1_q <= '0;
      tgt2_q <= '0;
    end else if (ce_in) begin
      ctrl_q <= ctrl_d;
      ttp_q  <= ttp_d;
      if (wr_t1_lo) tgt1_q[DW-1:0]  <= bus.wdata;
      if (wr_t1_hi) tgt1_q[TW-1:DW] <= bus.wdata;
      if (wr_t2_lo) tgt2_q[DW-1:0]  <= bus.wdata;
      if (wr_t2_hi) tgt2_q[TW-1:DW] <= bus.wdata;
    end
  end

  assign bus.target_compare_enable = {ctrl_q[CTL_TTE2], ctrl_q[CTL_TTE1]};

  //////////////////////////////////////////////////////////////////////////
  // external event and transmit snapshots

  wire ext_a_rise = ext_input_a_in && !ext_a_q;
  wire ext_b_rise = ext_input_b_in && !ext_b_q;
  wire master     = ctrl_q[CTL_MS];
  wire tx_trig    = master ? tx_sync_in : tx_delay_req_in;
  wire rx_trig    = master ? rx_delay_req_in : rx_sync_in;

  logic          ext_input_a_captured;
  logic          ext_input_b_captured;
  logic          tx_captured;
  logic [TW-1:0] ext_a_snap;
  logic [TW-1:0] ext_b_snap;
  logic [TW-1:0] tx_snap;

  ptpcc_capture #(.TW(TW)) u_cap_a (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .ce_in    (ce_in),
    .trig_in  (ext_a_rise),
    .clr_in   (w1c[EV_EXTA]),
    .time_in  (systime_q),
    .flag_out (ext_input_a_captured),
    .snap_out (ext_a_snap)
  );

  ptpcc_capture #(.TW(TW)) u_cap_b (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .ce_in    (ce_in),
    .trig_in  (ext_b_rise),
    .clr_in   (w1c[EV_EXTB]),
    .time_in  (systime_q),
    .flag_out (ext_input_b_captured),
    .snap_out (ext_b_snap)
  );

  ptpcc_capture #(.TW(TW)) u_cap_tx (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .ce_in    (ce_in),
    .trig_in  (tx_trig),
    .clr_in   (w1c[EV_TXS]),
    .time_in  (systime_q),
    .flag_out (tx_captured),
    .snap_out (tx_snap)
  );

  //////////////////////////////////////////////////////////////////////////
  // receive snapshot queue

  logic [QEW-1:0] rxq_mem [DEPTH];
  logic [QAW-1:0] rxq_wp_q;
  logic [QAW-1:0] rxq_rp_q;
  logic [QAW:0]   rxq_cnt_q;

  wire rxq_full  = (rxq_cnt_q == (QAW+1)'(DEPTH));
  wire rxs       = (rxq_cnt_q != '0);
  wire rxq_push  = rx_trig && !rxq_full;
  wire rxq_pop   = w1c[EV_RXS] && rxs;
  wire [QEW-1:0] rxq_head = rxq_mem[rxq_rp_q];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rxq_wp_q  <= '0;
      rxq_rp_q  <= '0;
      rxq_cnt_q <= '0;
    end else if (ce_in) begin
      if (rxq_push) rxq_wp_q <= rxq_wp_q + 1'b1;
      if (rxq_pop)  rxq_rp_q <= rxq_rp_q + 1'b1;
      rxq_cnt_q <= rxq_cnt_q + (QAW+1)'(rxq_push) - (QAW+1)'(rxq_pop);
    end
  end

  // storage has no reset, which keeps it a plain memory
  always_ff @(posedge clk_in) begin
    if (ce_in && rxq_push) begin
      rxq_mem[rxq_wp_q] <= {systime_q, rx_source_id_in, rx_sequence_id_in};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt, pps and read data

  wire [DW-1:0] event_rd = {10'h000, rxs, tx_captured, ext_input_b_captured,
                            ext_input_a_captured, ttp_q};

  // external event flags are left out on purpose, whatever their masks say
  wire irq_any = (ttp_q[0] && ctrl_q[CTL_TTM1])
               | (ttp_q[1] && ctrl_q[CTL_TTM2])
               | (tx_captured && ctrl_q[CTL_TXM])
               | (rxs && ctrl_q[CTL_RXM]);

  logic [DW-1:0] rd_mux;
  always_comb begin
    unique case (bus.addr)
      OFS_CTRL:    rd_mux = ctrl_q;
      OFS_EVENT:   rd_mux = event_rd;
      OFS_ADD_LO:  rd_mux = add_lo_q;
      OFS_ADD_HI:  rd_mux = add_hi_q;
      OFS_SYS_LO:  rd_mux = systime_q[DW-1:0];
      OFS_SYS_HI:  rd_mux = systime_q[TW-1:DW];
      OFS_TGT1_LO: rd_mux = tgt1_q[DW-1:0];
      OFS_TGT1_HI: rd_mux = tgt1_q[TW-1:DW];
      OFS_TGT2_LO: rd_mux = tgt2_q[DW-1:0];
      OFS_TGT2_HI: rd_mux = tgt2_q[TW-1:DW];
      OFS_EXTA_LO: rd_mux = ext_a_snap[DW-1:0];
      OFS_EXTA_HI: rd_mux = ext_a_snap[TW-1:DW];
      OFS_EXTB_LO: rd_mux = ext_b_snap[DW-1:0];
      OFS_EXTB_HI: rd_mux = ext_b_snap[TW-1:DW];
      OFS_TX_LO:   rd_mux = tx_snap[DW-1:0];
      OFS_TX_HI:   rd_mux = tx_snap[TW-1:DW];
      OFS_RX_LO:   rd_mux = rxq_head[QEW-TW+DW-1:2*IDW];
      OFS_RX_HI:   rd_mux = rxq_head[QEW-1:QEW-DW];
      OFS_RX_SRC:  rd_mux = rxq_head[2*IDW-1:IDW];
      OFS_RX_SEQ:  rd_mux = rxq_head[IDW-1:0];
      default:     rd_mux = REG_RST;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= REG_RST;
      irq_n_q <= 1'b1;
      pps_q   <= 1'b0;
      ext_a_q <= 1'b0;
      ext_b_q <= 1'b0;
    end else if (ce_in) begin
      if (bus.rd) begin
        rdata_q <= rd_mux;
      end
      irq_n_q <= !irq_any;
      pps_q   <= ctrl_q[CTL_PPSE] && ttp_q[1];
      ext_a_q <= ext_input_a_in;
      ext_b_q <= ext_input_b_in;
    end
  end

  assign bus.rdata           = rdata_q;
  assign bus.sync_irq_line_n = irq_n_q;
  assign pps_out             = pps_q;
  assign rx_queue_full_out   = rxq_full;
endmodule : ptpcc_dev

// [hw/ptpcc_pkg.sv]
package ptpcc_pkg;
  // bus shape
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int HAW = 7;
  localparam int TW = 32;
  localparam int IDW = 16;
  localparam int RXQ_DEPTH = 16;

  // device register offsets
  localparam logic [AW-1:0] OFS_CTRL     = 6'h00;
  localparam logic [AW-1:0] OFS_EVENT    = 6'h02;
  localparam logic [AW-1:0] OFS_ADD_LO   = 6'h04;
  localparam logic [AW-1:0] OFS_ADD_HI   = 6'h06;
  localparam logic [AW-1:0] OFS_SYS_LO   = 6'h0c;
  localparam logic [AW-1:0] OFS_SYS_HI   = 6'h0e;
  localparam logic [AW-1:0] OFS_TGT1_LO  = 6'h10;
  localparam logic [AW-1:0] OFS_TGT1_HI  = 6'h12;
  localparam logic [AW-1:0] OFS_TGT2_LO  = 6'h14;
  localparam logic [AW-1:0] OFS_TGT2_HI  = 6'h16;
  localparam logic [AW-1:0] OFS_EXTA_LO  = 6'h18;
  localparam logic [AW-1:0] OFS_EXTA_HI  = 6'h1a;
  localparam logic [AW-1:0] OFS_EXTB_LO  = 6'h1c;
  localparam logic [AW-1:0] OFS_EXTB_HI  = 6'h1e;
  localparam logic [AW-1:0] OFS_TX_LO    = 6'h20;
  localparam logic [AW-1:0] OFS_TX_HI    = 6'h22;
  localparam logic [AW-1:0] OFS_RX_LO    = 6'h24;
  localparam logic [AW-1:0] OFS_RX_HI    = 6'h26;
  localparam logic [AW-1:0] OFS_RX_SRC   = 6'h28;
  localparam logic [AW-1:0] OFS_RX_SEQ   = 6'h2a;

  // control field positions
  localparam int CTL_TTM1 = 0;
  localparam int CTL_TTM2 = 1;
  localparam int CTL_EVMA = 2;
  localparam int CTL_EVMB = 3;
  localparam int CTL_TTE1 = 4;
  localparam int CTL_TTE2 = 5;
  localparam int CTL_PPSE = 6;
  localparam int CTL_MS   = 7;
  localparam int CTL_TXM  = 8;
  localparam int CTL_RXM  = 9;
  localparam logic [DW-1:0] CTL_MASK = 16'h03ff;

  // event flag positions
  localparam int EV_TTP1 = 0;
  localparam int EV_SECOND_TARGET_PENDING = 1;
  localparam int EV_EXTA = 2;
  localparam int EV_EXTB = 3;
  localparam int EV_TXS  = 4;
  localparam int EV_RXS  = 5;

  localparam logic [DW-1:0] REG_RST = 16'h0000;

  // controller register offsets (software side)
  localparam logic [HAW-1:0] H_ADD_LO   = 7'h40;
  localparam logic [HAW-1:0] H_ADD_HI   = 7'h42;
  localparam logic [HAW-1:0] H_DRAIN    = 7'h44;
  localparam logic [HAW-1:0] H_STAT     = 7'h46;
  localparam logic [HAW-1:0] H_LAST_TLO = 7'h48;
  localparam logic [HAW-1:0] H_LAST_THI = 7'h4a;
  localparam logic [HAW-1:0] H_LAST_SRC = 7'h4c;
  localparam logic [HAW-1:0] H_LAST_SEQ = 7'h4e;
  localparam int H_SEL_BIT = 6;
endpackage : ptpcc_pkg

// [hw/ptpcc_if.sv]
`timescale 1ns/1ps
interface ptpcc_if;
  import ptpcc_pkg::*;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr;
  logic          rd;
  logic [DW-1:0] rdata;
  logic          sync_irq_line_n;
  logic [1:0]    target_compare_enable;

  modport dev (input addr, wdata, wr, rd,
               output rdata, sync_irq_line_n, target_compare_enable);
  modport host (output addr, wdata, wr, rd,
                input rdata, sync_irq_line_n, target_compare_enable);
endinterface : ptpcc_if

// [hw/ptpcc_capture.sv]
`timescale 1ns/1ps
module ptpcc_capture #(
  parameter int TW = 32
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  input  wire logic          ce_in,
  // trigger and time
  input  wire logic          trig_in,
  input  wire logic          clr_in,
  input  wire logic [TW-1:0] time_in,
  // snapshot
  output logic               flag_out,
  output logic [TW-1:0]      snap_out
);
  // a trigger in the clearing cycle is still caught, so no edge is lost to the clear
  logic take;
  assign take = trig_in && (!flag_out || clr_in);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_out <= 1'b0;
      snap_out <= '0;
    end else if (ce_in) begin
      if (take) begin
        flag_out <= 1'b1;
        snap_out <= time_in;
      end else if (clr_in) begin
        flag_out <= 1'b0;
      end
    end
  end
endmodule : ptpcc_capture

// [hw/ptpcc_host.sv]
`timescale 1ns/1ps
module ptpcc_host
  import ptpcc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic                  ce_in,
  // software port
  input  wire logic [ptpcc_pkg::HAW-1:0] sw_addr_in,
  input  wire logic [ptpcc_pkg::DW-1:0]  sw_wdata_in,
  input  wire logic                  sw_wr_in,
  input  wire logic                  sw_rd_in,
  output logic [ptpcc_pkg::DW-1:0]   sw_rdata_out,
  // status
  output logic                       irq_out,
  output logic                       busy_out,
  // device side
  ptpcc_if.host                      bus
);
  import ptpcc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_ADD_LO = 4'b0001,
    ST_ADD_HI = 4'b0010,
    ST_RD_EV  = 4'b0011,
    ST_CHK    = 4'b0100,
    ST_RD_TLO = 4'b0101,
    ST_RD_THI = 4'b0110,
    ST_RD_SRC = 4'b0111,
    ST_RD_SEQ = 4'b1000,
    ST_CLR    = 4'b1001
  } ptpcc_state_t;

  ptpcc_state_t  st_q;
  ptpcc_state_t  st_d;
  logic [DW-1:0] add_lo_q;
  logic [DW-1:0] add_hi_q;
  logic [DW-1:0] last_q [4];
  logic [7:0]    drained_q;
  logic          refused_q;
  logic [1:0]    ext_seen_q;
  logic [DW-1:0] own_rdata_q;
  logic          own_sel_q;

  //////////////////////////////////////////////////////////////////////////
  // software decode

  wire idle   = (st_q == ST_IDLE);
  wire is_own = sw_addr_in[H_SEL_BIT];
  wire [AW-1:0] dev_addr = sw_addr_in[AW-1:0];
  wire tgt1_w = (dev_addr == OFS_TGT1_LO) || (dev_addr == OFS_TGT1_HI);
  wire tgt2_w = (dev_addr == OFS_TGT2_LO) || (dev_addr == OFS_TGT2_HI);
  // a target write while its compare runs could fire a false match
  wire guard  = (tgt1_w && bus.target_compare_enable[0])
              || (tgt2_w && bus.target_compare_enable[1]);
  wire pass_wr = idle && sw_wr_in && !is_own && !guard;
  wire pass_rd = idle && sw_rd_in && !is_own;
  wire own_wr  = idle && sw_wr_in && is_own;
  wire start_add   = own_wr && (sw_addr_in == H_ADD_HI);
  wire start_drain = own_wr && (sw_addr_in == H_DRAIN);

  //////////////////////////////////////////////////////////////////////////
  // sequencer: addend load and receive queue drain

  wire seq_wr = (st_q == ST_ADD_LO) || (st_q == ST_ADD_HI)
              || (st_q == ST_CLR);
  wire seq_rd = (st_q == ST_RD_EV) || (st_q == ST_RD_TLO)
              || (st_q == ST_RD_THI) || (st_q == ST_RD_SRC)
              || (st_q == ST_RD_SEQ);
  wire rxs_now = bus.rdata[EV_RXS];

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start_add) st_d = ST_ADD_LO;
        else if (start_drain) st_d = ST_RD_EV;
      end
      ST_ADD_LO: st_d = ST_ADD_HI;
      ST_ADD_HI: st_d = ST_IDLE;
      ST_RD_EV:  st_d = ST_CHK;
      ST_CHK:    st_d = rxs_now ? ST_RD_TLO : ST_IDLE;
      ST_RD_TLO: st_d = ST_RD_THI;
      ST_RD_THI: st_d = ST_RD_SRC;
      ST_RD_SRC: st_d = ST_RD_SEQ;
      ST_RD_SEQ: st_d = ST_CLR;
      ST_CLR:    st_d = ST_RD_EV;
      default:   st_d = ST_IDLE;
    endcase
  end

  logic [AW-1:0] seq_addr;
  always_comb begin
    unique case (st_q)
      ST_ADD_LO: seq_addr = OFS_ADD_LO;
      ST_ADD_HI: seq_addr = OFS_ADD_HI;
      ST_RD_TLO: seq_addr = OFS_RX_LO;
      ST_RD_THI: seq_addr = OFS_RX_HI;
      ST_RD_SRC: seq_addr = OFS_RX_SRC;
      ST_RD_SEQ: seq_addr = OFS_RX_SEQ;
      default:   seq_addr = OFS_EVENT;
    endcase
  end

  wire [DW-1:0] seq_wdata = (st_q == ST_ADD_LO) ? add_lo_q
                          : (st_q == ST_ADD_HI) ? add_hi_q
                          : (DW)'(1) << EV_RXS;

  assign bus.addr  = idle ? dev_addr : seq_addr;
  assign bus.wdata = idle ? sw_wdata_in : seq_wdata;
  assign bus.wr    = idle ? pass_wr : seq_wr;
  assign bus.rd    = idle ? pass_rd : seq_rd;

  //////////////////////////////////////////////////////////////////////////
  // state and captures

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q       <= ST_IDLE;
      add_lo_q   <= REG_RST;
      add_hi_q   <= REG_RST;
      drained_q  <= 8'h00;
      refused_q  <= 1'b0;
      ext_seen_q <= 2'b00;
      for (int i = 0; i < 4; i++) last_q[i] <= REG_RST;
    end else if (ce_in) begin
      st_q <= st_d;
      if (own_wr && (sw_addr_in == H_ADD_LO)) add_lo_q <= sw_wdata_in;
      if (start_add) add_hi_q <= sw_wdata_in;
      if (start_drain) drained_q <= 8'h00;
      if (idle && sw_wr_in && !is_own && guard) refused_q <= 1'b1;
      if (own_wr && (sw_addr_in == H_STAT)) refused_q <= 1'b0;
      // event flags are trusted only once polled as set
      if (st_q == ST_CHK) begin
        ext_seen_q <= bus.rdata[EV_EXTB:EV_EXTA];
      end
      if (st_q == ST_RD_THI) last_q[0] <= bus.rdata;
      if (st_q == ST_RD_SRC) last_q[1] <= bus.rdata;
      if (st_q == ST_RD_SEQ) last_q[2] <= bus.rdata;
      if (st_q == ST_CLR) begin
        last_q[3]  <= bus.rdata;
        drained_q  <= drained_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software read path

  wire [DW-1:0] stat = {drained_q, 4'h0, ext_seen_q, refused_q, !idle};
  wire [DW-1:0] own_mux = (sw_addr_in == H_ADD_LO)   ? add_lo_q
                        : (sw_addr_in == H_ADD_HI)   ? add_hi_q
                        : (sw_addr_in == H_STAT)     ? stat
                        : (sw_addr_in == H_LAST_TLO) ? last_q[0]
                        : (sw_addr_in == H_LAST_THI) ? last_q[1]
                        : (sw_addr_in == H_LAST_SRC) ? last_q[2]
                        : (sw_addr_in == H_LAST_SEQ) ? last_q[3]
                        : REG_RST;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      own_rdata_q <= REG_RST;
      own_sel_q   <= 1'b1;
    end else if (ce_in) begin
      if (sw_rd_in) begin
        own_rdata_q <= (is_own && idle) ? own_mux : REG_RST;
        own_sel_q   <= is_own || !idle;
      end
    end
  end

  assign sw_rdata_out = own_sel_q ? own_rdata_q : bus.rdata;
  assign irq_out      = !bus.sync_irq_line_n;
  assign busy_out     = !idle;
endmodule : ptpcc_host

// [tb/ptpcc_sva.sv]
`timescale 1ns/1ps
module ptpcc_sva
  import ptpcc_pkg::*;
(
  // clock and reset
  input wire logic          clk_in,
  input wire logic          rstn_in,
  // device bus
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic [DW-1:0] rdata,
  input wire logic          sync_irq_line_n,
  input wire logic [1:0]    target_compare_enable
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // addend readback is only known to be zero until software touches it
  logic add_seen_q;
  wire  add_wr = wr && (addr == OFS_ADD_LO || addr == OFS_ADD_HI);
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) add_seen_q <= 1'b0;
    else if (add_wr) add_seen_q <= 1'b1;
  //////////////////////////////////////////////////////////////////////////
  property p_add_pair;
    wr && addr == OFS_ADD_HI |-> $past(wr && addr == OFS_ADD_LO);
  endproperty
  a_add_pair: assert property (p_add_pair)
    else $error("addend high half without low half");
  property p_add_rst;
    rd && (addr == OFS_ADD_LO || addr == OFS_ADD_HI) && !add_seen_q
      |=> rdata == REG_RST;
  endproperty
  a_add_rst: assert property (p_add_rst)
    else $error("addend not zero after reset");
  property p_tce_rise;
    $rose(target_compare_enable[0])
      |-> $past(wr && addr == OFS_CTRL && wdata[CTL_TTE1]);
  endproperty
  a_tce_rise: assert property (p_tce_rise)
    else $error("compare enable set without a write");
  property p_ctrl_tce;
    rd && addr == OFS_CTRL |=> rdata[5:4] == $past(target_compare_enable);
  endproperty
  a_ctrl_tce: assert property (p_ctrl_tce)
    else $error("compare enable readback mismatch");
  property p_irq_off;
    wr && addr == OFS_CTRL && (wdata & 16'h0303) == 16'h0000
      |-> ##2 sync_irq_line_n;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt with every mask clear");
  property p_ev_clear;
    wr && addr == OFS_EVENT && wdata[EV_TTP1] && !target_compare_enable[0]
      ##1 !wr && !target_compare_enable[0]
      ##1 rd && addr == OFS_EVENT && !target_compare_enable[0]
      |=> !rdata[EV_TTP1];
  endproperty
  a_ev_clear: assert property (p_ev_clear)
    else $error("pending flag survived a clear");
  property p_ctrl_back;
    wr && addr == OFS_CTRL ##1 !wr ##1 rd && addr == OFS_CTRL
      |=> (rdata & 16'h03cf) == ($past(wdata, 3) & 16'h03cf);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back)
    else $error("control readback mismatch");
  // rdata and the line both lag the flags by one cycle, so they line up
  property p_ev_upper;
    rd && addr == OFS_EVENT |=> rdata[15:6] == 10'h000
      && (rdata[5:4] != 2'b00 || rdata[1:0] != 2'b00 || sync_irq_line_n);
  endproperty
  a_ev_upper: assert property (p_ev_upper)
    else $error("interrupt with no maskable flag set");
endmodule : ptpcc_sva

// [tb/tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
  import ptpcc_pkg::*;
  logic           clk_in, rstn_in, sw_wr, sw_rd, irq, busy, pps, full;
  logic [HAW-1:0] sw_addr;
  logic [DW-1:0]  sw_wdata, sw_rdata, v, s;
  logic [1:0]     ext;
  logic [3:0]     fr;
  logic [IDW-1:0] src_id;
  int             fail_count, checks;
  ptpcc_if bus_if ();
  ptpcc_dev ptpcc_dev_i (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .bus(bus_if.dev), .ext_input_a_in(ext[0]), .ext_input_b_in(ext[1]),
    .tx_sync_in(fr[0]), .tx_delay_req_in(fr[1]), .rx_sync_in(fr[2]),
    .rx_delay_req_in(fr[3]), .rx_source_id_in(src_id),
    .rx_sequence_id_in(~src_id), .pps_out(pps), .rx_queue_full_out(full));
  ptpcc_host ptpcc_host_i (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr),
    .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata), .irq_out(irq),
    .busy_out(busy), .bus(bus_if.host));
  ptpcc_sva ptpcc_sva_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
    .rd(bus_if.rd), .rdata(bus_if.rdata),
    .sync_irq_line_n(bus_if.sync_irq_line_n),
    .target_compare_enable(bus_if.target_compare_enable));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic wr7(input logic [HAW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_in);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk_in);
    sw_wr <= 1'b0;
  endtask : wr7
  task automatic rd7(input logic [HAW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk_in);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : rd7
  task automatic rchk(input logic [HAW-1:0] a, input logic [DW-1:0] e);
    rd7(a, v);
    `CHK($sformatf("reg %h", a), e, v)
  endtask : rchk
  // flags reach the pins a cycle after the register, so let them land
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic pulse(input int k);
    @(posedge clk_in);
    fr[k] <= 1'b1;
    @(posedge clk_in);
    fr <= 4'h0;
  endtask : pulse
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn_in, sw_addr, sw_wdata, sw_wr, sw_rd, ext, fr, src_id} = '0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 8; i += 2) rchk(7'(i), 16'h0000);
    rchk(7'h0c, 16'h0000);
    rchk(7'h3e, 16'h0000);
    wr7(7'h00, 16'h0010);
    rchk(7'h00, 16'h0000);
    rchk(7'h02, 16'h0001);
    `CHK("irq", 1'b0, irq)
    wr7(7'h00, 16'h0001);
    settle();
    `CHK("irq", 1'b1, irq)
    wr7(7'h02, 16'h0001);
    rchk(7'h02, 16'h0000);
    `CHK("irq", 1'b0, irq)
    wr7(7'h00, 16'h0060);
    settle();
    `CHK("pps", 1'b1, pps)
    wr7(7'h00, 16'h0000);
    settle();
    `CHK("pps", 1'b0, pps)
    wr7(7'h02, 16'h0002);
    // all ones makes time step by exactly one each cycle
    wr7(H_ADD_LO, 16'hffff);
    wr7(H_ADD_HI, 16'hffff);
    repeat (4) @(posedge clk_in);
    rchk(7'h04, 16'hffff);
    rchk(7'h06, 16'hffff);
    rd7(7'h0c, s);
    rd7(7'h0c, v);
    `CHK("time step", s + 16'h0002, v)
    wr7(7'h00, 16'h000c);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      ext[k] <= 1'b1;
      settle();
      rchk(7'h02, 16'h0004 << k);
      `CHK("irq", 1'b0, irq)
      rd7(7'(24 + 4 * k), s);
      @(posedge clk_in) ext[k] <= 1'b0;
      settle();
      @(posedge clk_in) ext[k] <= 1'b1;
      settle();
      rchk(7'(24 + 4 * k), s);
      wr7(7'h02, 16'h0004 << k);
      rchk(7'h02, 16'h0000);
      @(posedge clk_in) ext[k] <= 1'b0;
    end
    wr7(7'h00, 16'h0100);
    pulse(0);
    rchk(7'h02, 16'h0000);
    pulse(1);
    rchk(7'h02, 16'h0010);
    `CHK("irq", 1'b1, irq)
    rd7(7'h20, s);
    pulse(1);
    rchk(7'h20, s);
    wr7(7'h02, 16'h0010);
    rchk(7'h02, 16'h0000);
    wr7(7'h00, 16'h0080);
    pulse(0);
    rchk(7'h02, 16'h0010);
    `CHK("irq", 1'b0, irq)
    wr7(7'h02, 16'h0010);
    wr7(7'h00, 16'h0200);
    src_id <= 16'hffff;
    pulse(3);
    for (int i = 0; i < 17; i++) begin
      src_id <= 16'(i);
      pulse(2);
    end
    settle();
    `CHK("full", 1'b1, full)
    `CHK("irq", 1'b1, irq)
    for (int i = 0; i < 16; i++) begin
      rchk(7'h02, 16'h0020);
      rchk(7'h28, 16'(i));
      rchk(7'h2a, ~16'(i));
      wr7(7'h02, 16'h0020);
    end
    rchk(7'h02, 16'h0000);
    settle();
    `CHK("irq", 1'b0, irq)
    // target 1 is zero and long past, so the compare stays armed
    wr7(7'h00, 16'h0010);
    wr7(7'h10, 16'h1234);
    rchk(7'h10, 16'h0000);
    rchk(H_STAT, 16'h0002);
    wr7(H_STAT, 16'h0000);
    wr7(7'h00, 16'h0000);
    rd7(7'h0c, s);
    wr7(7'h10, s + 16'h0040);
    wr7(7'h00, 16'h0010);
    repeat (80) @(posedge clk_in);
    rchk(7'h02, 16'h0001);
    rchk(7'h00, 16'h0000);
    @(posedge clk_in) ext[0] <= 1'b1;
    repeat (2) pulse(2);
    wr7(H_DRAIN, 16'h0000);
    settle();
    `CHK("busy", 1'b1, busy)
    for (int i = 0; i < 64 && busy; i++) @(posedge clk_in);
    #1 `CHK("busy", 1'b0, busy)
    rchk(H_STAT, 16'h0204);
    rchk(H_LAST_SRC, 16'h0010);
    rchk(H_LAST_SEQ, 16'hffef);
    rchk(7'h02, 16'h0005);
    summarize();
  end
endmodule : tb_top
